//--- src/efm_top.sv
// e1 framer mode control: control words, ais detection, ts0 word build
// Function
// - criteria zero: under three zeros per 512
// - criteria one: two consecutive quiet windows needed
// - multiframe pulse follows signalling or crc multiframe
// - national bits from buffer or control field
// - selected sa bits carry data link, termination
// - transparent mode forces sa4 as link
// - unselected sa bits come from national buffer or field
// - national field resets to bf (ones except bit six), feeds bits 4-8
// - international bits sent only without crc-4
// - crc remainder modify in transparent mode
// - soft reset rising edge restores defaults
// - automatic a bit follows basic sync
// - remote alarm bit in nfas bit three
// - remote alarm ignored while auto enabled
// - y bit automatic or manual
// - transparent passes backplane data unframed
// - crc sync overrides international bits
// - interworking follows its disable bit
`timescale 1ns/1ps

module efm_top
    import efm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire efm_cpu_s   cpu_req,
    output logic [7:0]      cpu_rdata,
    input  wire efm_rx_s    rx,
    input  wire logic       basic_sync_ok,
    input  wire logic       mf_aligned,
    input  wire efm_tx_s    tx,
    input  wire logic [7:0] backplane_tx_data_in,
    output logic            ais_detect,
    output logic            rx_multiframe_pulse,
    output logic [7:0]      tx_ts0_word,
    output logic            tx_y_bit,
    output efm_ctl_s        ctl
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0] dl_sel;
        logic [7:0] mode;
        logic [7:0] nfa;
        logic [7:0] rdata;
        logic [8:0] bit_cnt;
        logic [1:0] zeros;
        efm_ais_e   ais;
        logic       mf_pulse;
        logic [7:0] ts0;
        logic       y_bit;
    } efm_state_s;

    localparam efm_state_s STATE_RST = '{
        dl_sel:   DLSEL_RST,
        mode:     MODE_RST,
        nfa:      NFA_RST,
        rdata:    RD_NONE,
        bit_cnt:  9'h000,
        zeros:    2'h0,
        ais:      AIS_CLR,
        mf_pulse: 1'b0,
        ts0:      TS0_RST,
        y_bit:    1'b1
    };

    efm_state_s s_r;
    efm_state_s s_nxt;

    logic       win_end;
    logic [1:0] zeros_now;
    logic       win_quiet;
    logic       soft_rst;
    logic       transp;
    logic [4:0] link_sel;

    // ****************************************************************
    // register read decode
    // ****************************************************************
    function automatic logic [7:0] reg_read(
        input logic [4:0] addr,
        input efm_state_s st
    );
        logic [7:0] v;
        v = RD_NONE;
        if (addr == REG_DLSEL)
            v = st.dl_sel;
        else if (addr == REG_MODE)
            v = st.mode;
        else if (addr == REG_NFA)
            v = st.nfa;
        return v;
    endfunction

    // ****************************************************************
    // helpers shared by logic and checks
    // ****************************************************************
    assign transp    = s_r.mode[MD_TXTR];
    assign win_end   = rx.bit_en && (s_r.bit_cnt == AIS_WIN_LAST);
    assign zeros_now = (!rx.bit_val && (s_r.zeros != AIS_ZERO_LIMIT))
                       ? s_r.zeros + 2'h1 : s_r.zeros;
    assign win_quiet = zeros_now != AIS_ZERO_LIMIT;
    assign soft_rst  = cpu_req.wr && (cpu_req.addr == REG_MODE)
                       && cpu_req.wdata[MD_SRST] && !s_r.mode[MD_SRST];
    assign link_sel  = transp ? SA4_ONLY : s_r.dl_sel[SA_W-1:0];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic [4:0] nat;
        logic [4:0] sa;
        logic       intl;
        logic       a_bit;
        s_nxt = s_r;
        nat   = 5'h00;
        sa    = 5'h00;
        intl  = 1'b0;
        a_bit = 1'b0;

        // host writes; bit six of nfa is stored as written
        if (cpu_req.wr)
        begin
            if (cpu_req.addr == REG_DLSEL)
                s_nxt.dl_sel = cpu_req.wdata;
            else if (cpu_req.addr == REG_MODE)
                s_nxt.mode = cpu_req.wdata;
            else if (cpu_req.addr == REG_NFA)
                s_nxt.nfa = cpu_req.wdata;
        end
        if (cpu_req.rd)
            s_nxt.rdata = reg_read(cpu_req.addr, s_r);

        // 512-bit window, zero count saturates at the limit
        if (rx.bit_en)
        begin
            if (win_end)
            begin
                s_nxt.bit_cnt = 9'h000;
                s_nxt.zeros   = 2'h0;
                if (!win_quiet)
                    s_nxt.ais = AIS_CLR;
                else if (!s_r.dl_sel[DL_AIS_CRIT])
                    s_nxt.ais = AIS_ON;
                else
                begin
                    case (s_r.ais)
                        AIS_CLR:  s_nxt.ais = AIS_PEND;
                        AIS_PEND: s_nxt.ais = AIS_ON;
                        AIS_ON:   s_nxt.ais = AIS_ON;
                        default:  s_nxt.ais = AIS_CLR;
                    endcase
                end
            end
            else
            begin
                s_nxt.bit_cnt = s_r.bit_cnt + 9'h001;
                s_nxt.zeros   = zeros_now;
            end
        end

        s_nxt.mf_pulse = s_r.dl_sel[DL_PULSE_SRC] ? rx.crc_mf : rx.sig_mf;

        nat = s_r.dl_sel[DL_NAT_BUF] ? tx.nb_buf : s_r.nfa[SA_W-1:0];
        sa  = (link_sel & tx.dl_bits) | (~link_sel & nat);
        if (!s_r.mode[MD_CRC_OFF])
            intl = tx.crc_bit;
        else if (tx.frame_fas)
            intl = s_r.mode[MD_INTL_FAS];
        else
            intl = s_r.nfa[NF_INTL_NFAS];
        a_bit = s_r.mode[MD_RAI_MAN] ? s_r.nfa[NF_REM_ALARM] : !basic_sync_ok;

        // word loaded only at frame start or by soft reset
        if (tx.frame_start)
        begin
            if (transp)
            begin
                s_nxt.ts0 = backplane_tx_data_in;
                if (!tx.frame_fas)
                    s_nxt.ts0[SA_W-1] = tx.dl_bits[SA_W-1];
            end
            else if (tx.frame_fas)
                s_nxt.ts0 = {intl, FAS_PATTERN};
            else
                s_nxt.ts0 = {intl, 1'b1, a_bit, sa};
            s_nxt.y_bit = s_r.mode[MD_Y_MAN] ? tx.man_y : !mf_aligned;
        end

        if (soft_rst)
            s_nxt = STATE_RST;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_r <= STATE_RST;
        else
            s_r <= s_nxt;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cpu_rdata           = s_r.rdata;
    assign ais_detect          = (s_r.ais == AIS_ON);
    assign rx_multiframe_pulse = s_r.mf_pulse;
    assign tx_ts0_word         = s_r.ts0;
    assign tx_y_bit            = s_r.y_bit;
    assign ctl.tx_transparent       = transp;
    assign ctl.crc_sync_en          = !s_r.mode[MD_CRC_OFF];
    assign ctl.crc_interwork_en     = !s_r.mode[MD_IWK_OFF];
    assign ctl.crc_remainder_modify = transp && s_r.mode[MD_REM_MOD];
    assign ctl.dl_sa_active         = link_sel;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence quiet_win_s;
        win_end && win_quiet && !soft_rst;
    endsequence

    sequence nfas_term_s;
        tx.frame_start && !tx.frame_fas && !transp && !soft_rst;
    endsequence

    sequence fas_term_s;
        tx.frame_start && tx.frame_fas && !transp && !soft_rst;
    endsequence

    ais_single_a: assert property (
        quiet_win_s ##0 !s_r.dl_sel[DL_AIS_CRIT] |=> ais_detect)
        else $error("ais not raised after quiet window");

    ais_double_a: assert property (
        quiet_win_s ##0 s_r.dl_sel[DL_AIS_CRIT] && s_r.ais == AIS_CLR
        |=> !ais_detect)
        else $error("ais raised after one window in double mode");

    ais_clear_a: assert property (
        win_end && !win_quiet |=> !ais_detect)
        else $error("ais held after noisy window");

    mf_pulse_a: assert property (
        !soft_rst |=> rx_multiframe_pulse == $past(
            s_r.dl_sel[DL_PULSE_SRC] ? rx.crc_mf : rx.sig_mf))
        else $error("multiframe pulse from wrong source");

    sa_merge_a: assert property (
        nfas_term_s |=> tx_ts0_word[SA_W-1:0] ==
            (($past(s_r.dl_sel[SA_W-1:0]) & $past(tx.dl_bits))
            | (~$past(s_r.dl_sel[SA_W-1:0]) & $past(
                s_r.dl_sel[DL_NAT_BUF] ? tx.nb_buf : s_r.nfa[SA_W-1:0]))))
        else $error("sa bits mixed wrongly");

    auto_abit_a: assert property (
        nfas_term_s ##0 !s_r.mode[MD_RAI_MAN]
        |=> tx_ts0_word[TS_ABIT] == !$past(basic_sync_ok))
        else $error("a bit does not track basic sync");

    man_abit_a: assert property (
        nfas_term_s ##0 s_r.mode[MD_RAI_MAN]
        |=> tx_ts0_word[TS_ABIT] == $past(s_r.nfa[NF_REM_ALARM]))
        else $error("a bit does not follow remote alarm");

    intl_fas_a: assert property (
        fas_term_s ##0 s_r.mode[MD_CRC_OFF]
        |=> tx_ts0_word == {$past(s_r.mode[MD_INTL_FAS]), FAS_PATTERN})
        else $error("fas word wrong without crc");

    crc_bit_a: assert property (
        (fas_term_s or nfas_term_s) ##0 !s_r.mode[MD_CRC_OFF]
        |=> tx_ts0_word[TS_INTL] == $past(tx.crc_bit))
        else $error("crc bit not in bit one");

    transp_a: assert property (
        tx.frame_start && !tx.frame_fas && transp && !soft_rst
        |=> tx_ts0_word == {$past(backplane_tx_data_in[7:5]),
            $past(tx.dl_bits[SA_W-1]), $past(backplane_tx_data_in[3:0])})
        else $error("transparent word wrong");

    y_bit_a: assert property (
        tx.frame_start && !s_r.mode[MD_Y_MAN] && !soft_rst
        |=> tx_y_bit == !$past(mf_aligned))
        else $error("y bit does not track alignment");

    ts0_hold_a: assert property (
        !tx.frame_start && !soft_rst |=> $stable(tx_ts0_word))
        else $error("ts0 word changed inside a frame");

    soft_rst_a: assert property (
        soft_rst |=> s_r.mode == MODE_RST && s_r.nfa == NFA_RST
        && s_r.dl_sel == DLSEL_RST && tx_ts0_word == TS0_RST)
        else $error("soft reset did not restore defaults");

    mode_out_a: assert property (
        cpu_req.wr && cpu_req.addr == REG_MODE && !soft_rst
        |=> ctl.crc_remainder_modify == ($past(cpu_req.wdata[MD_TXTR])
            && $past(cpu_req.wdata[MD_REM_MOD]))
        && ctl.crc_interwork_en == !$past(cpu_req.wdata[MD_IWK_OFF]))
        else $error("mode outputs do not follow mode write");

endmodule

//--- src/efm_pkg.sv
// constants, types and carriers for the e1 framer mode control block
package efm_pkg;

    // ****************************************************************
    // register map and reset values
    // ****************************************************************
    localparam logic [4:0] REG_DLSEL = 5'h10;
    localparam logic [4:0] REG_MODE  = 5'h11;
    localparam logic [4:0] REG_NFA   = 5'h12;
    localparam logic [7:0] DLSEL_RST = 8'h00;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] NFA_RST   = 8'hBF;
    localparam logic [7:0] RD_NONE   = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int DL_AIS_CRIT  = 7;
    localparam int DL_PULSE_SRC = 6;
    localparam int DL_NAT_BUF   = 5;
    localparam int MD_INTL_FAS  = 7;
    localparam int MD_REM_MOD   = 6;
    localparam int MD_SRST      = 5;
    localparam int MD_RAI_MAN   = 4;
    localparam int MD_Y_MAN     = 3;
    localparam int MD_TXTR      = 2;
    localparam int MD_CRC_OFF   = 1;
    localparam int MD_IWK_OFF   = 0;
    localparam int NF_INTL_NFAS = 7;
    localparam int NF_REM_ALARM = 5;
    localparam int SA_W         = 5;

    // ****************************************************************
    // time slot zero layout, bit 1 of the slot is word bit 7
    // ****************************************************************
    localparam int TS_INTL   = 7;
    localparam int TS_FIXED  = 6;
    localparam int TS_ABIT   = 5;
    localparam logic [6:0] FAS_PATTERN = 7'h1B;
    localparam logic [4:0] SA4_ONLY    = 5'h10;
    localparam logic [7:0] TS0_RST     = 8'hFF;

    // ****************************************************************
    // alarm indication detection
    // ****************************************************************
    localparam logic [8:0] AIS_WIN_LAST   = 9'h1FF;
    localparam logic [1:0] AIS_ZERO_LIMIT = 2'h3;

    typedef enum logic [1:0] {
        AIS_CLR  = 2'b00,
        AIS_PEND = 2'b01,
        AIS_ON   = 2'b11
    } efm_ais_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } efm_cpu_s;

    typedef struct packed {
        logic bit_en;
        logic bit_val;
        logic sig_mf;
        logic crc_mf;
    } efm_rx_s;

    typedef struct packed {
        logic       frame_start;
        logic       frame_fas;
        logic       crc_bit;
        logic [4:0] nb_buf;
        logic [4:0] dl_bits;
        logic       man_y;
    } efm_tx_s;

    typedef struct packed {
        logic       tx_transparent;
        logic       crc_sync_en;
        logic       crc_interwork_en;
        logic       crc_remainder_modify;
        logic [4:0] dl_sa_active;
    } efm_ctl_s;

endpackage

//--- verif/efm_line_model.sv
// far-end line model: receive bit stream with set zeros per window and multiframe pulses
`timescale 1ns/1ps

module efm_line_model
    import efm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [1:0] nz,
    output efm_rx_s         rx,
    output logic            win_end
);
    logic [8:0] cnt_r;

    // zeros sit at the end of each 512-bit window, so a change of nz at window start is safe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_r   <= 9'h000;
            rx      <= '0;
            win_end <= 1'b0;
        end
        else
        begin
            rx.bit_en  <= run;
            win_end    <= run && (cnt_r == 9'h1FF);
            // an idle line shows the inverse of the last bit, never a stale copy
            rx.bit_val <= run ? (({1'b0, cnt_r} + nz) < 10'h200) : ~rx.bit_val;
            rx.sig_mf  <= run && (cnt_r[3:0] == 4'h5);
            rx.crc_mf  <= run && (cnt_r[3:0] == 4'h9);
            if (run)
            begin
                cnt_r <= cnt_r + 9'h001;
            end
        end
    end
endmodule

//--- verif/efm_top_test.sv
// self-checking testbench for the e1 framer mode control block
`timescale 1ns/1ps

module efm_top_test;
    import efm_pkg::*;
    logic       ref_clk;
    logic       rst;
    efm_cpu_s   cpu_req;
    efm_rx_s    rx;
    efm_tx_s    tx;
    logic       basic_sync_ok, mf_aligned, run, win_end, rd_d, fs_d;
    logic [1:0] nz;
    logic [7:0] bp, cpu_rdata, tx_ts0_word, dl, md, nf;
    logic       ais_detect, rx_multiframe_pulse, tx_y_bit;
    efm_ctl_s   ctl;
    logic [8:0] last;
    logic [7:0] rq[$];
    logic [8:0] tq[$];
    logic [3:0] tab [6] = '{4'b0001, 4'b0110, 4'b0101, 4'b1110, 4'b1000, 4'b1001};
    int         failures, checks;

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    efm_top u_efm_top (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .rx(rx), .basic_sync_ok(basic_sync_ok), .mf_aligned(mf_aligned), .tx(tx),
        .backplane_tx_data_in(bp), .ais_detect(ais_detect),
        .rx_multiframe_pulse(rx_multiframe_pulse), .tx_ts0_word(tx_ts0_word),
        .tx_y_bit(tx_y_bit), .ctl(ctl));

    efm_line_model u_efm_line_model (.ref_clk(ref_clk), .rst(rst), .run(run), .nz(nz), .rx(rx),
        .win_end(win_end));

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cpu_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        cpu_req.wr <= 1'b0;
        if (a == REG_DLSEL) dl = d;
        if (a == REG_MODE) md = d;
        if (a == REG_NFA) nf = d;
        if (a == REG_MODE && d[MD_SRST])
        begin
            dl = DLSEL_RST;
            md = MODE_RST;
            nf = NFA_RST;
        end
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rq.push_back(e);
        cpu_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        cpu_req.rd <= 1'b0;
    endtask

    task automatic rd_all();
        rd_reg(REG_DLSEL, dl);
        rd_reg(REG_MODE, md);
        rd_reg(REG_NFA, nf);
    endtask

    function automatic logic [8:0] exp_ctl();
        return {md[MD_TXTR], !md[MD_CRC_OFF], !md[MD_IWK_OFF], md[MD_TXTR] & md[MD_REM_MOD],
                md[MD_TXTR] ? SA4_ONLY : dl[4:0]};
    endfunction

    // ts0 word built from shadow registers and the frame inputs
    task automatic frame(input logic fas);
        efm_tx_s    t;
        logic       bs, ma, b1, a, y;
        logic [7:0] b, w;
        logic [4:0] sel, sa;
        t = 14'($urandom);
        t.frame_start = 1'b1;
        t.frame_fas = fas;
        {bs, ma, b} = 10'($urandom);
        sel = md[MD_TXTR] ? SA4_ONLY : dl[4:0];
        b1 = md[MD_CRC_OFF] ? (fas ? md[MD_INTL_FAS] : nf[NF_INTL_NFAS]) : t.crc_bit;
        a = md[MD_RAI_MAN] ? nf[NF_REM_ALARM] : !bs;
        sa = (sel & t.dl_bits) | (~sel & (dl[DL_NAT_BUF] ? t.nb_buf : nf[4:0]));
        w = fas ? {b1, FAS_PATTERN} : {b1, 1'b1, a, sa};
        if (md[MD_TXTR])
        begin
            w = b;
            if (!fas) w[4] = t.dl_bits[4];
        end
        y = md[MD_Y_MAN] ? t.man_y : !ma;
        last = {y, w};
        tq.push_back(last);
        @(posedge ref_clk);
        tx <= t;
        basic_sync_ok <= bs;
        mf_aligned <= ma;
        bp <= b;
        @(posedge ref_clk);
        tx.frame_start <= 1'b0;
    endtask

    // expectation taken at the edge the design samples, before the model moves on
    task automatic mf_chk();
        int   k;
        logic e;
        e = 1'b0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge ref_clk);
            e = dl[DL_PULSE_SRC] ? rx.crc_mf : rx.sig_mf;
            if ((rx.sig_mf | rx.crc_mf) === 1'b1) break;
        end
        if (k == 40)
        begin
            failures++;
            report_and_stop();
        end
        @(negedge ref_clk);
        chk(rx_multiframe_pulse, e);
    endtask

    // results are taken off the queues as they appear
    always @(posedge ref_clk)
    begin
        rd_d <= cpu_req.rd;
        fs_d <= tx.frame_start;
    end

    always @(negedge ref_clk)
    begin
        if (rd_d === 1'b1)
            chk(cpu_rdata, (rq.size() > 0) ? rq.pop_front() : 9'h1FF);
        if (fs_d === 1'b1)
            chk({tx_y_bit, tx_ts0_word}, (tq.size() > 0) ? tq.pop_front() : 9'h000);
    end

    initial
    begin
        rst = 1'b1;
        cpu_req = '0;
        tx = '0;
        {basic_sync_ok, mf_aligned, run, nz, bp} = '0;
        {failures, checks} = '0;
        {dl, md, nf} = {DLSEL_RST, MODE_RST, NFA_RST};
        last = {1'b1, TS0_RST};
        void'($urandom(47017));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk({tx_y_bit, tx_ts0_word}, last);
        chk(ctl, exp_ctl());
        rd_all();
        wr_reg(5'h13, 8'h5A);
        rd_reg(5'h13, RD_NONE);
        $display("test reset and map done");
        repeat (24)
        begin
            wr_reg(REG_DLSEL, 8'($urandom));
            wr_reg(REG_MODE, 8'($urandom) & 8'hDF);
            wr_reg(REG_NFA, 8'($urandom) & 8'hBF);
            @(negedge ref_clk);
            chk({tx_y_bit, tx_ts0_word}, last);
            chk(ctl, exp_ctl());
            rd_all();
            frame(1'b0);
            frame(1'b1);
        end
        $display("test ts0 build done");
        @(posedge ref_clk);
        run <= 1'b1;
        foreach (tab[i])
        begin
            @(posedge ref_clk);
            nz <= tab[i][2:1];
            wr_reg(REG_DLSEL, {tab[i][3], tab[i][3], 6'h00});
            mf_chk();
            mf_chk();
            for (int k = 0; k <= 600; k++)
            begin
                @(posedge ref_clk);
                if (win_end === 1'b1) break;
                if (k == 600)
                begin
                    failures++;
                    report_and_stop();
                end
            end
            @(negedge ref_clk);
            chk(ais_detect, tab[i][0]);
        end
        $display("test ais and multiframe done");
        wr_reg(REG_MODE, 8'h20);
        @(negedge ref_clk);
        chk(ais_detect, 1'b0);
        chk({tx_y_bit, tx_ts0_word}, {1'b1, TS0_RST});
        chk(ctl, exp_ctl());
        rd_all();
        repeat (3) @(posedge ref_clk);
        $display("test soft reset done");
        report_and_stop();
    end
endmodule
